//--- consec_counter.sv
module consec_counter #(
  parameter int LIMIT = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic clear_i,
  input  wire logic sample_i,
  input  wire logic hit_i,
  output logic      trip_o
);

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIMIT_M1 = CW'(LIMIT - 1);

  logic [CW-1:0] count_ff;
  logic [CW-1:0] nxt_count;
  wire           reach = sample_i && hit_i && (count_ff >= LIMIT_M1);

  //////////////////////////////////////////////////////////////////////////////
  // Any clean sample restarts the run of offending cycles
  assign nxt_count = clear_i                  ? '0 :
                     (sample_i && !hit_i)     ? '0 :
                     (sample_i && !reach)     ? count_ff + CW'(1) :
                     reach                    ? '0 : count_ff;

  // Trip is a one-cycle pulse in the cycle after the final offending sample
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_ff <= '0;
      trip_o   <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      trip_o   <= reach && !clear_i;
    end
  end

endmodule

//--- flyback_fault_mode_sequencer.sv
// What this block does
// [R01] Every fault takes one path: lockout reset, then full restart.
// [R02] Feedback sample above 4.6 V on three cycles in a row is overvoltage.
// [R03] After overvoltage stop switching, fault bias until turn-off, then restart.
// [R04] Line current sampled only while the switch is on and pin clamped.
// [R05] Run at 225 uA line current, stop below 80 uA, with hysteresis.
// [R06] Each on-time ends when sensed current reaches the commanded peak.
// [R07] Sense at 1.5 V after blanking three cycles running forces restart.
// [R08] First four power cycles are limited to the minimum sense threshold.
// [R09] Minimum threshold not reached within 4 us on cycle one means short.
// [R10] Open sense input reads as 1.5 V and trips the same counter.
// [R11] Overtemperature starts lockout cycle; repeats while still hot.
// [R12] Loss of feedback information stops switching and restarts.
// [R13] Below turn-on threshold keep the high-voltage source charging.
// [R14] Above turn-on, disable the source and begin regulated switching.
// [R15] Constant-current mode while output is below regulation.
// [R16] Constant-voltage mode while load is below the current limit.
// [R17] Peak above 0.55 of maximum keeps the run state, no waits.
// [R18] Light constant-voltage load waits after each cycle, runs for each.
// [R19] Supply below turn-off stops switching, start bias, source on.
// [R20] Fault holds fault bias to turn-off, then start bias and charging.
// [R21] A persisting fault repeats discharge and recharge indefinitely.
// [R22] Consecutive counters clear on clean samples and on start entry.
// [R23] Comparator flags are synchronised and read at fixed sample instants.
//
// Decided for this implementation: the address map and the plain strobed port.
`include "flyback_seq_defines.svh"

module flyback_fault_mode_sequencer #(
  parameter int LEB_CYC    = 25,
  parameter int MAX_ON_CYC = 1000
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Comparator flags from the analog front end
  input  wire logic        vdd_above_on_i,
  input  wire logic        vdd_below_off_i,
  input  wire logic        over_temp_i,
  input  wire logic        fb_over_volt_i,
  input  wire logic        fb_lost_i,
  input  wire logic        line_above_run_i,
  input  wire logic        line_below_stop_i,
  input  wire logic        cs_at_peak_i,
  input  wire logic        cs_at_min_i,
  input  wire logic        cs_at_limit_i,
  // Requests from the regulation logic, same clock
  input  wire logic        cycle_req_i,
  input  wire logic        fb_sample_i,
  input  wire logic        out_below_reg_i,
  input  wire logic        peak_above_frac_i,
  // Register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Power stage controls
  output logic             gate_o,
  output logic             hv_source_en_o,
  output logic             bias_start_o,
  output logic             bias_wait_o,
  output logic             bias_fault_o,
  output logic             min_peak_limit_o,
  output logic             cc_mode_o
);

  localparam int SW = 10;
  localparam logic [9:0] LEB_LAST   = 10'(LEB_CYC - 1);
  localparam logic [9:0] SHORT_LAST = 10'(`CS_SHORT_CYC - 1);
  localparam logic [9:0] MAXON_LAST = 10'(MAX_ON_CYC - 1);
  localparam logic [2:0] START_N    = 3'(`STARTUP_MIN_CYCLES);

  //////////////////////////////////////////////////////////////////////////////
  // Synchronised comparator flags
  logic [SW-1:0] raw_flags;
  logic [SW-1:0] flags;

  assign raw_flags = {vdd_above_on_i, vdd_below_off_i, over_temp_i, fb_over_volt_i,
                      fb_lost_i, line_above_run_i, line_below_stop_i, cs_at_peak_i,
                      cs_at_min_i, cs_at_limit_i};

  // All analog decisions arrive through the agreeing synchroniser
  sync_agree #(
    .WIDTH (SW)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (raw_flags),
    .sync_o  (flags)
  ); // [R23]

  wire vdd_on    = flags[9];
  wire vdd_off   = flags[8];
  wire hot       = flags[7];
  wire fb_ovp    = flags[6];
  wire fb_lost   = flags[5];
  wire line_run  = flags[4];
  wire line_stop = flags[3];
  wire cs_peak   = flags[2];
  wire cs_min    = flags[1];
  wire cs_limit  = flags[0];

  //////////////////////////////////////////////////////////////////////////////
  // State and registers
  flyback_seq_pkg::seq_state_type state_ff;
  flyback_seq_pkg::seq_state_type nxt_state;

  logic [9:0]               on_cnt_ff;
  logic [2:0]               startup_cnt_ff;
  logic                     line_ok_ff;
  logic                     cs_min_seen_ff;
  logic [1:0]               ctrl_ff;
  logic [`CAUSE_WIDTH-1:0]  cause_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire wr_ctrl   = wr_i && (addr_i == `REG_CTRL_ADDR);
  wire wr_cause  = wr_i && (addr_i == `REG_CAUSE_ADDR);
  wire soft_kick = wr_ctrl && wdata_i[`CTRL_RESTART_BIT];
  wire enabled   = ctrl_ff[`CTRL_ENABLE_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // On-time events
  wire in_start   = (state_ff == flyback_seq_pkg::ST_START);
  wire in_on      = (state_ff == flyback_seq_pkg::ST_ON);
  wire in_fault   = (state_ff == flyback_seq_pkg::ST_FAULT);
  wire blank_done = in_on && (on_cnt_ff >= LEB_LAST);
  wire limiting   = (startup_cnt_ff < START_N);
  // Line current only meaningful while the switch is on and the pin is clamped
  wire line_smp   = blank_done; // [R04]
  // Peak reached ends the on-time; a runaway on-time is cut by the maximum
  wire peak_end   = blank_done && (cs_peak || (cs_min && limiting) ||
                    (on_cnt_ff >= MAXON_LAST)); // [R06] [R08]
  // First cycle: the minimum threshold must appear inside the short window
  wire first_cyc  = in_on && (startup_cnt_ff == 3'h0);
  wire cs_short   = first_cyc && !cs_min && !cs_min_seen_ff &&
                    (on_cnt_ff >= SHORT_LAST); // [R09]
  wire cyc_end    = peak_end && !cs_short;

  //////////////////////////////////////////////////////////////////////////////
  // Consecutive-cycle fault counters
  logic ovp_trip;
  logic ocp_trip;

  // Feedback overvoltage counted at the regulation sample instant
  consec_counter #(
    .LIMIT (`FAULT_REPEAT_CYCLES)
  ) u_ovp_cnt (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .clear_i  (in_start),
    .sample_i (fb_sample_i && !in_start && !in_fault),
    .hit_i    (fb_ovp),
    .trip_o   (ovp_trip)
  ); // [R02] [R22]

  // Overcurrent counted at end of each on-time; open pin reads as limit
  consec_counter #(
    .LIMIT (`FAULT_REPEAT_CYCLES)
  ) u_ocp_cnt (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .clear_i  (in_start),
    .sample_i (cyc_end),
    .hit_i    (cs_limit),
    .trip_o   (ocp_trip)
  ); // [R07] [R10] [R22]

  //////////////////////////////////////////////////////////////////////////////
  // Fault collection; all causes share one lockout restart path
  wire fb_lost_hit = fb_sample_i && fb_lost && !in_start && !in_fault; // [R12]
  wire hot_hit     = hot && !in_start && !in_fault; // [R11]

  logic [`CAUSE_WIDTH-1:0] new_cause;

  assign new_cause[`CAUSE_OVP_BIT]    = ovp_trip;
  assign new_cause[`CAUSE_OCP_BIT]    = ocp_trip;
  assign new_cause[`CAUSE_SHORT_BIT]  = cs_short;
  assign new_cause[`CAUSE_TEMP_BIT]   = hot_hit || (in_start && vdd_on && hot);
  assign new_cause[`CAUSE_FBLOST_BIT] = fb_lost_hit;
  assign new_cause[`CAUSE_SOFT_BIT]   = soft_kick && !in_fault;

  wire any_fault = |new_cause; // [R01]

  //////////////////////////////////////////////////////////////////////////////
  // Next-state decision
  wire light_cv = !out_below_reg_i && !peak_above_frac_i;
  // Line current is only measurable during an on-time, so the first cycle after
  // a start is a probe; without it a cold start could never qualify the line
  wire probe_cyc = (startup_cnt_ff == 3'h0);
  wire may_run   = enabled && (line_ok_ff || probe_cyc); // [R05]

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      flyback_seq_pkg::ST_START: begin
        // Charge until turn-on; a still-hot die goes straight back to fault
        if (vdd_on && hot) begin
          nxt_state = flyback_seq_pkg::ST_FAULT; // [R11]
        end else if (vdd_on) begin
          nxt_state = flyback_seq_pkg::ST_IDLE; // [R14]
        end
      end
      flyback_seq_pkg::ST_IDLE,
      flyback_seq_pkg::ST_WAIT: begin
        if (any_fault) begin
          nxt_state = flyback_seq_pkg::ST_FAULT;
        end else if (vdd_off) begin
          nxt_state = flyback_seq_pkg::ST_START; // [R19]
        end else if (cycle_req_i && may_run) begin
          nxt_state = flyback_seq_pkg::ST_ON; // [R18]
        end
      end
      flyback_seq_pkg::ST_ON: begin
        if (any_fault) begin
          nxt_state = flyback_seq_pkg::ST_FAULT;
        end else if (vdd_off) begin
          nxt_state = flyback_seq_pkg::ST_START; // [R19]
        end else if (cyc_end && light_cv) begin
          nxt_state = flyback_seq_pkg::ST_WAIT; // [R18]
        end else if (cyc_end) begin
          nxt_state = flyback_seq_pkg::ST_IDLE; // [R17]
        end
      end
      flyback_seq_pkg::ST_FAULT: begin
        // Fault bias discharges the supply; restart once it reaches turn-off
        if (vdd_off) begin
          nxt_state = flyback_seq_pkg::ST_START; // [R03] [R20] [R21]
        end
      end
      default: begin
        nxt_state = flyback_seq_pkg::ST_START;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= flyback_seq_pkg::ST_START;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // On-time counter, zero outside the on state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      on_cnt_ff <= '0;
    end else if (in_on && nxt_state == flyback_seq_pkg::ST_ON) begin
      on_cnt_ff <= (on_cnt_ff == 10'h3FF) ? on_cnt_ff : on_cnt_ff + 10'h001;
    end else begin
      on_cnt_ff <= '0;
    end
  end

  // Minimum threshold seen during the first cycle, cleared each cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_min_seen_ff <= 1'b0;
    end else begin
      cs_min_seen_ff <= in_on && (cs_min_seen_ff || cs_min); // [R09]
    end
  end

  // Power cycle count since start; saturates once limiting ends
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      startup_cnt_ff <= '0;
    end else if (in_start) begin
      startup_cnt_ff <= '0;
    end else if (cyc_end && limiting) begin
      startup_cnt_ff <= startup_cnt_ff + 3'h1; // [R08]
    end
  end

  // Line qualification with wide hysteresis; sampled only at clamp time
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_ok_ff <= 1'b0;
    end else if (line_smp && line_run) begin
      line_ok_ff <= 1'b1; // [R05]
    end else if (line_smp && line_stop) begin
      line_ok_ff <= 1'b0; // [R05]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software registers; a new cause wins over a clear in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff  <= `CTRL_RESET_VALUE;
      cause_ff <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= {1'b0, wdata_i[`CTRL_ENABLE_BIT]};
      end
      if (wr_cause) begin
        cause_ff <= (cause_ff & ~wdata_i[`CAUSE_WIDTH-1:0]) | new_cause;
      end else begin
        cause_ff <= cause_ff | new_cause;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  assign status_word = {21'h0, startup_cnt_ff, 2'h0, cc_mode_o, line_ok_ff,
                        1'b0, state_ff};
  assign rd_mux = (addr_i == `REG_CTRL_ADDR)   ? {30'h0, ctrl_ff} :
                  (addr_i == `REG_STATUS_ADDR) ? status_word :
                  (addr_i == `REG_CAUSE_ADDR)  ? {26'h0, cause_ff} : 32'h0000_0000;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output stage, every control straight from a flip-flop
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gate_o           <= 1'b0;
      hv_source_en_o   <= 1'b1;
      bias_start_o     <= 1'b1;
      bias_wait_o      <= 1'b0;
      bias_fault_o     <= 1'b0;
      min_peak_limit_o <= 1'b1;
      cc_mode_o        <= 1'b0;
    end else begin
      gate_o           <= (nxt_state == flyback_seq_pkg::ST_ON); // [R06]
      hv_source_en_o   <= (nxt_state == flyback_seq_pkg::ST_START); // [R13] [R14]
      bias_start_o     <= (nxt_state == flyback_seq_pkg::ST_START); // [R19] [R20]
      bias_wait_o      <= (nxt_state == flyback_seq_pkg::ST_WAIT); // [R18]
      bias_fault_o     <= (nxt_state == flyback_seq_pkg::ST_FAULT); // [R03] [R20]
      min_peak_limit_o <= limiting; // [R08]
      // Constant current while output is low, else constant voltage
      cc_mode_o        <= out_below_reg_i; // [R15] [R16]
    end
  end

endmodule

//--- flyback_fault_mode_sequencer_tb_top.sv
`include "flyback_seq_defines.svh"
module flyback_fault_mode_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0;
  logic        vdd_above_on_i, vdd_below_off_i, line_above_run_i, line_below_stop_i;
  logic        cs_at_peak_i, cs_at_min_i, cs_at_limit_i;
  logic        over_temp_i = 0, fb_over_volt_i = 0, fb_lost_i = 0, cycle_req_i = 0;
  logic        fb_sample_i = 0, out_below_reg_i = 0, peak_above_frac_i = 0;
  logic [3:0]  addr_i = 0;
  logic [31:0] wdata_i = 0, rdata_o;
  logic        gate_o, hv_source_en_o, bias_start_o, bias_wait_o, bias_fault_o;
  logic        min_peak_limit_o, cc_mode_o, line_hi = 1;
  logic [1:0]  cs_mode = 2'd2;
  logic [6:0]  mon;
  int          miscompares = 0, n_compared = 0, cycles = 0;

  // Watched outputs gathered so waits can be indexed
  assign mon = {bias_start_o, min_peak_limit_o, cc_mode_o, bias_wait_o,
                bias_fault_o, hv_source_en_o, gate_o};

  flyback_fault_mode_sequencer dut (.clk_i, .rst_i, .vdd_above_on_i, .vdd_below_off_i,
    .over_temp_i, .fb_over_volt_i, .fb_lost_i, .line_above_run_i, .line_below_stop_i,
    .cs_at_peak_i, .cs_at_min_i, .cs_at_limit_i, .cycle_req_i, .fb_sample_i,
    .out_below_reg_i, .peak_above_frac_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .gate_o, .hv_source_en_o, .bias_start_o, .bias_wait_o, .bias_fault_o,
    .min_peak_limit_o, .cc_mode_o);

  flyback_stage_model stage (.clk_i(clk_i), .gate_i(gate_o), .src_en_i(hv_source_en_o),
    .fault_bias_i(bias_fault_o), .line_hi_i(line_hi), .cs_mode_i(cs_mode),
    .above_on_o(vdd_above_on_i), .below_off_o(vdd_below_off_i),
    .line_run_o(line_above_run_i), .line_stop_o(line_below_stop_i),
    .cs_peak_o(cs_at_peak_i), .cs_min_o(cs_at_min_i), .cs_limit_o(cs_at_limit_i));

  //////////////////////////////////////////////////////////////
  // Clock and a hang guard well above the longest expected run
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      $display("BAD %0t run did not finish", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic bit_is(input int i, input logic v);
    chk(32'(mon[i]), 32'(v));
  endtask

  // Bounded wait; a timeout shows up as a miscompare
  task automatic wait_for(input int i, input logic v);
    int n;
    n = 0;
    while (mon[i] !== v && n < 3000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    bit_is(i, v);
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 0;
    #1;
    chk(rdata_o, exp);
  endtask

  // Flag is set well ahead of the sample pulse to clear the synchroniser
  task automatic sample_fb(input logic ov, input int cnt);
    repeat (cnt) begin
      @(posedge clk_i);
      fb_over_volt_i <= ov;
      repeat (7) @(posedge clk_i);
      fb_sample_i <= 1;
      @(posedge clk_i);
      fb_sample_i <= 0;
      repeat (7) @(posedge clk_i);
    end
  endtask

  //////////////////////////////////////////////////////////////
  initial begin
    int limited;
    int n;
    repeat (6) @(posedge clk_i);
    #1;
    chk(32'(mon), 32'h0000_0062);
    @(posedge clk_i);
    rst_i <= 0;
    cycle_req_i <= 1;
    reg_rd(`REG_CTRL_ADDR, 32'(`CTRL_RESET_VALUE));
    reg_rd(4'hC, 32'h0000_0000);
    // Shorted sense on the very first cycle
    wait_for(1, 0);
    wait_for(0, 1);
    wait_for(2, 1);
    reg_rd(`REG_CAUSE_ADDR, 32'h0000_0004);
    @(posedge clk_i);
    cs_mode <= 2'd0;
    reg_wr(`REG_CAUSE_ADDR, 32'h0000_003F);
    wait_for(1, 1);
    wait_for(1, 0);
    // Count limited cycles; light load waits after each one
    limited = 0;
    repeat (8) begin
      wait_for(0, 1);
      if (min_peak_limit_o === 1'b1)
        limited++;
      wait_for(0, 0);
      bit_is(3, 1);
    end
    chk(32'(limited), 32'(`STARTUP_MIN_CYCLES));
    @(posedge clk_i);
    peak_above_frac_i <= 1;
    wait_for(0, 1);
    wait_for(0, 0);
    bit_is(3, 0);
    @(posedge clk_i);
    out_below_reg_i <= 1;
    wait_for(0, 1);
    wait_for(0, 0);
    bit_is(4, 1);
    @(posedge clk_i);
    out_below_reg_i <= 0;
    peak_above_frac_i <= 0;
    wait_for(0, 1);
    wait_for(0, 0);
    bit_is(4, 0);
    // Broken runs of overvoltage samples must not trip
    sample_fb(1, 2);
    sample_fb(0, 1);
    sample_fb(1, 2);
    sample_fb(0, 1);
    reg_rd(`REG_CAUSE_ADDR, 32'h0000_0000);
    // Each fault kind except the short (k == 2): trip, cause, discharge, recharge, run again
    for (int k = 0; k < 6; k++) begin
      if (k != 2) begin
        @(posedge clk_i);
        cs_mode <= (k == 1) ? 2'd1 : 2'd0;
        over_temp_i <= (k == 3);
        fb_lost_i <= (k == 4);
        if (k == 0 || k == 4)
          sample_fb(1'(k == 0), 3);
        if (k == 5)
          reg_wr(`REG_CTRL_ADDR, 32'h0000_0003);
        wait_for(2, 1);
        bit_is(0, 0);
        reg_rd(`REG_CAUSE_ADDR, 32'(1 << k));
        if (k == 3) begin
          wait_for(2, 0);
          wait_for(2, 1);
        end
        @(posedge clk_i);
        cs_mode <= 2'd0;
        over_temp_i <= 0;
        fb_lost_i <= 0;
        fb_over_volt_i <= 0;
        reg_wr(`REG_CAUSE_ADDR, 32'h0000_003F);
        wait_for(2, 0);
        wait_for(1, 1);
        bit_is(6, 1);
        wait_for(0, 1);
      end
    end
    // Line drops under stop: no further cycles
    @(posedge clk_i);
    line_hi <= 0;
    wait_for(0, 0);
    reg_rd(`REG_STATUS_ADDR, 32'h0000_0102);
    n = 0;
    repeat (300) begin
      @(posedge clk_i);
      #1;
      if (gate_o === 1'b1)
        n++;
    end
    chk(32'(n), 32'h0000_0000);
    tally_and_finish();
  end
endmodule

//--- flyback_seq_chk.sv
module flyback_seq_chk (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic vdd_above_on_i,
  input  wire logic vdd_below_off_i,
  input  wire logic peak_above_frac_i,
  input  wire logic gate_o,
  input  wire logic hv_source_en_o,
  input  wire logic bias_start_o,
  input  wire logic bias_wait_o,
  input  wire logic bias_fault_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Comparator held long enough to cross the synchroniser and the state flop
  sequence supply_low_s;
    vdd_below_off_i [*8];
  endsequence
  sequence supply_high_s;
    (vdd_above_on_i && !vdd_below_off_i) [*8];
  endsequence

  //////////////////////////////////////////////////////////////
  gate_excl_a: assert property (
    gate_o |-> !hv_source_en_o && !bias_start_o && !bias_fault_o)
    else $error("switching with start or fault bias");
  run_bias_a: assert property (gate_o |-> !bias_wait_o)
    else $error("wait bias during on-time");
  bias_onehot_a: assert property ($onehot0({bias_start_o, bias_wait_o, bias_fault_o}))
    else $error("two bias levels at once");
  src_start_a: assert property (hv_source_en_o |-> bias_start_o)
    else $error("source on without start bias");
  fault_entry_a: assert property ($rose(bias_fault_o) |-> !gate_o && !hv_source_en_o)
    else $error("fault entered while switching or charging");
  fault_exit_a: assert property ($fell(bias_fault_o) |-> hv_source_en_o && bias_start_o)
    else $error("fault left without start bias and source");
  supply_low_a: assert property (supply_low_s |-> hv_source_en_o && !gate_o)
    else $error("low supply without charging");
  supply_high_a: assert property (supply_high_s |-> !hv_source_en_o)
    else $error("source still on above turn-on");
  light_load_a: assert property ($fell(gate_o) && $past(peak_above_frac_i) |-> !bias_wait_o)
    else $error("wait bias with heavy peak");
endmodule

bind flyback_fault_mode_sequencer flyback_seq_chk chk (
  .clk_i(clk_i), .rst_i(rst_i), .vdd_above_on_i(vdd_above_on_i),
  .vdd_below_off_i(vdd_below_off_i), .peak_above_frac_i(peak_above_frac_i),
  .gate_o(gate_o), .hv_source_en_o(hv_source_en_o), .bias_start_o(bias_start_o),
  .bias_wait_o(bias_wait_o), .bias_fault_o(bias_fault_o));

//--- flyback_seq_defines.svh
`ifndef FLYBACK_SEQ_DEFINES_SVH
`define FLYBACK_SEQ_DEFINES_SVH

// Register byte addresses
`define REG_CTRL_ADDR        4'h0
`define REG_STATUS_ADDR      4'h4
`define REG_CAUSE_ADDR       4'h8

// Control register fields
`define CTRL_ENABLE_BIT      0
`define CTRL_RESTART_BIT     1
`define CTRL_RESET_VALUE     2'h1

// Fault cause fields, sticky, write one to clear
`define CAUSE_OVP_BIT        0
`define CAUSE_OCP_BIT        1
`define CAUSE_SHORT_BIT      2
`define CAUSE_TEMP_BIT       3
`define CAUSE_FBLOST_BIT     4
`define CAUSE_SOFT_BIT       5
`define CAUSE_WIDTH          6

// Status register fields
`define STAT_STATE_LSB       0
`define STAT_LINE_OK_BIT     4
`define STAT_CC_MODE_BIT     5
`define STAT_STARTUP_LSB     8

// Timing
`define CLK_PERIOD_NS        8
`define CS_SHORT_TIME_NS     4000
`define CS_SHORT_CYC         (`CS_SHORT_TIME_NS / `CLK_PERIOD_NS)

// Cycle counts
`define FAULT_REPEAT_CYCLES  3
`define STARTUP_MIN_CYCLES   4

`endif

//--- flyback_seq_pkg.sv
package flyback_seq_pkg;

  // Operating state of the sequencer
  typedef enum logic [2:0] {
    ST_START,
    ST_IDLE,
    ST_WAIT,
    ST_ON,
    ST_FAULT
  } seq_state_type;

endpackage

//--- flyback_stage_model.sv
module flyback_stage_model (
  input  wire logic       clk_i,
  input  wire logic       gate_i,
  input  wire logic       src_en_i,
  input  wire logic       fault_bias_i,
  input  wire logic       line_hi_i,
  input  wire logic [1:0] cs_mode_i,
  output logic            above_on_o,
  output logic            below_off_o,
  output logic            line_run_o,
  output logic            line_stop_o,
  output logic            cs_peak_o,
  output logic            cs_min_o,
  output logic            cs_limit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int lvl    = 0;
  int on_cnt = 0;

  // Supply charges from the source, sags on fault bias, aux winding holds it
  always @(posedge clk_i) begin
    if (src_en_i)
      lvl <= lvl + 1;
    else if (fault_bias_i && lvl > 0)
      lvl <= lvl - 1;
    on_cnt <= gate_i ? on_cnt + 1 : 0;
  end

  // Comparators; sense ramp is slow enough to outlast blanking
  assign above_on_o  = lvl >= 60;
  assign below_off_o = lvl <= 20;
  assign line_run_o  = gate_i && line_hi_i;
  assign line_stop_o = gate_i && !line_hi_i;
  assign cs_limit_o  = cs_mode_i == 2'd1;
  assign cs_min_o    = cs_limit_o || (cs_mode_i == 2'd0 && on_cnt >= 8);
  assign cs_peak_o   = cs_limit_o || (cs_mode_i == 2'd0 && on_cnt >= 40);
endmodule

//--- sync_agree.sv
module sync_agree #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Three stages per bit; a change is taken only once stages two and three agree,
  // so a single metastable sample never reaches the sequencer
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          stage1_ff[i] <= 1'b0;
          stage2_ff[i] <= 1'b0;
          stage3_ff[i] <= 1'b0;
          sync_o[i]    <= 1'b0;
        end else begin
          stage1_ff[i] <= async_i[i];
          stage2_ff[i] <= stage1_ff[i];
          stage3_ff[i] <= stage2_ff[i];
          if (stage2_ff[i] == stage3_ff[i]) begin
            sync_o[i] <= stage3_ff[i];
          end
        end
      end
    end
  endgenerate

endmodule
